// ==== common/amo_pkg.sv ====
// Constants, types and timing tables for the auto-monitor oversampling block
`default_nettype none

package amo_pkg;

  // ****************************************
  // Clock and bus geometry
  // ****************************************
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned CELL_COUNT = 16;
  localparam int unsigned CHAN_COUNT = 24;

  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [7:0] IDX_SCAN_PERIOD = 8'h32;
  localparam logic [7:0] IDX_SCAN_MASK = 8'h33;
  localparam logic [7:0] IDX_AVG_CTRL = 8'h37;
  localparam logic [7:0] IDX_CELL_INTERVAL = 8'h3e;
  localparam logic [7:0] IDX_AUX_INTERVAL = 8'h3f;
  localparam logic [7:0] IDX_STATUS = 8'h40;
  localparam logic [7:0] IDX_RESULT_BASE = 8'h48;
  localparam logic [7:0] IDX_RESULT_LAST = 8'h5f;

  // ****************************************
  // Field positions, write masks and reset values
  // ****************************************
  localparam int unsigned ORDER_BIT = 7;
  localparam int unsigned ANALOG_LSB = 5;
  localparam int unsigned DIGITAL_LSB = 3;
  localparam int unsigned COUNT_LSB = 0;
  localparam int unsigned CELL_IVL_LSB = 4;
  localparam logic [2:0] MAX_COUNT_CODE = 3'h5;
  localparam logic [31:0] SCAN_MASK_WMASK = 32'hffff_ff84;
  localparam logic [7:0] AVG_CTRL_RESET = 8'h00;
  localparam logic [3:0] SCAN_PERIOD_RESET = 4'h0;
  localparam logic [31:0] SCAN_MASK_RESET = 32'h0000_0000;
  localparam logic [7:0] CELL_INTERVAL_RESET = 8'h00;
  localparam logic [31:0] AUX_INTERVAL_RESET = 32'h0000_0000;

  // ****************************************
  // Timing tables
  // ****************************************
  localparam int unsigned INTERVAL_NS [16] = '{4130, 5960, 8020, 10000, 12600, 14900, 17400,
    19900, 24900, 30000, 40100, 60000, 100000, 200000, 500000, 1000000};
  localparam logic [3:0] IVL_200US = 4'hd;
  localparam logic [3:0] IVL_500US = 4'he;
  localparam logic [3:0] IVL_1000US = 4'hf;
  localparam logic [3:0] ANALOG_PERIOD_IVL = 4'h4;
  localparam logic [3:0] DIGITAL_PERIOD_IVL [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned SCAN_PERIOD_MS [16] = '{0, 1, 2, 5, 10, 50, 100, 200, 500, 1000,
    2000, 5000, 10000, 60000, 1800000, 3600000};

  // Least time, rounded up to whole cycles
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEEK = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_CONV = 4'b1000
  } amo_state_type;

endpackage

`default_nettype wire

// ==== logic/amo_round.sv ====
// Convergent rounding of an accumulated sum down to a 16-bit average
`default_nettype none

module amo_round (
  input wire logic [20:0] sum,
  input wire logic [2:0] shift,
  output logic [15:0] avg
);

  // ****************************************
  // Round half to even
  // ****************************************
  wire [20:0] quot = sum >> shift;
  wire [20:0] rem_mask = 21'((22'h1 << shift) - 22'h1);
  wire [20:0] half = 21'((22'h1 << shift) >> 1);
  wire [20:0] rem = sum & rem_mask;
  wire up = (shift != 3'h0) && ((rem > half) || ((rem == half) && quot[0]));
  wire [20:0] rounded = quot + {20'h0, up};
  // Saturate: a full-scale mean that rounds up must not wrap
  assign avg = (rounded > 21'h00ffff) ? 16'hffff : rounded[15:0];

endmodule

`default_nettype wire

// ==== logic/amo_sequencer.sv ====
// Auto-monitor oversampling sequencer with APB registers and period timer
//
// The APB interface to the registers was chosen for this implementation.
`default_nettype none

module amo_sequencer
  import amo_pkg::*;
#(
  parameter int unsigned MS_CYCLES = ns_to_cycles(MS_NS),
  parameter int unsigned IVL_200US_CYCLES = ns_to_cycles(INTERVAL_NS[13]),
  parameter int unsigned IVL_500US_CYCLES = ns_to_cycles(INTERVAL_NS[14]),
  parameter int unsigned IVL_1000US_CYCLES = ns_to_cycles(INTERVAL_NS[15])
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic adc_start,
  output logic [4:0] adc_channel,
  input wire logic adc_done,
  input wire logic [15:0] adc_result,
  output logic scan_busy
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] avg_ctrl;
  logic [3:0] scan_period;
  logic [31:0] scan_mask;
  logic [7:0] cell_interval;
  logic [31:0] aux_interval;
  logic [15:0] results [CHAN_COUNT];
  logic [20:0] acc [CHAN_COUNT];
  amo_state_type state;
  logic [4:0] ch;
  logic [4:0] from;
  logic grp;
  logic [4:0] samp;
  logic [15:0] wait_cnt;
  logic run_order;
  logic [2:0] run_count;
  logic [4:0] run_last;
  logic [23:0] run_sel;
  logic [15:0] ms_cnt;
  logic [21:0] per_cnt;
  logic start_req;

  // ****************************************
  // APB decode; one wait state so read data comes from a flop
  // ****************************************
  wire apb_access = psel && penable && !pready;
  wire apb_done = psel && penable && pready;
  wire [7:0] idx = paddr[ADDR_W-1:2];
  wire is_result = (idx >= IDX_RESULT_BASE) && (idx <= IDX_RESULT_LAST);
  wire [4:0] ridx = 5'(idx - IDX_RESULT_BASE);
  wire mapped = is_result || (idx == IDX_SCAN_PERIOD) || (idx == IDX_SCAN_MASK) ||
    (idx == IDX_AVG_CTRL) || (idx == IDX_CELL_INTERVAL) || (idx == IDX_AUX_INTERVAL) ||
    (idx == IDX_STATUS);
  wire wr_any = apb_done && pwrite;
  wire wr_ctrl = wr_any && (idx == IDX_AVG_CTRL);
  wire wr_period = wr_any && (idx == IDX_SCAN_PERIOD);
  wire wr_mask = wr_any && (idx == IDX_SCAN_MASK);
  wire wr_cell = wr_any && (idx == IDX_CELL_INTERVAL);
  wire wr_aux = wr_any && (idx == IDX_AUX_INTERVAL);
  wire [31:0] status_word = {20'h0, scan_busy, grp, samp, ch};
  wire [31:0] rdata = (idx == IDX_SCAN_PERIOD) ? {28'h0, scan_period} :
    (idx == IDX_SCAN_MASK) ? scan_mask :
    (idx == IDX_AVG_CTRL) ? {24'h0, avg_ctrl} :
    (idx == IDX_CELL_INTERVAL) ? {24'h0, cell_interval} :
    (idx == IDX_AUX_INTERVAL) ? aux_interval :
    (idx == IDX_STATUS) ? status_word :
    is_result ? {16'h0, results[ridx]} : 32'h0;
  // Reserved count codes are folded onto the largest legal one
  wire [2:0] wr_count = pwdata[2:0];
  wire [2:0] wr_count_ok = (wr_count > MAX_COUNT_CODE) ? MAX_COUNT_CODE : wr_count;

  // APB answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access;
      prdata <= (apb_access && !pwrite) ? rdata : 32'h0;
      pslverr <= apb_access && !mapped;
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_ctrl <= AVG_CTRL_RESET;
      scan_period <= SCAN_PERIOD_RESET;
      scan_mask <= SCAN_MASK_RESET;
      cell_interval <= CELL_INTERVAL_RESET;
      aux_interval <= AUX_INTERVAL_RESET;
    end else begin
      if (wr_ctrl) avg_ctrl <= {pwdata[7:3], wr_count_ok};
      if (wr_period) scan_period <= pwdata[3:0];
      if (wr_mask) scan_mask <= pwdata & SCAN_MASK_WMASK;
      if (wr_cell) cell_interval <= pwdata[7:0];
      if (wr_aux) aux_interval <= pwdata;
    end
  end

  // ****************************************
  // Auto-monitor period timer
  // ****************************************
  wire [21:0] period_ms = 22'(SCAN_PERIOD_MS[scan_period]);
  wire ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
  wire period_hit = ms_tick && (scan_period != 4'h0) && (per_cnt == period_ms - 22'h1);
  wire take_start = (state == ST_IDLE) && start_req;
  // A new trigger beats the take, so a scan that overruns its period loops again
  wire set_start = (wr_period && (pwdata[3:0] != 4'h0)) || period_hit;
  wire next_start_req = set_start || (start_req && !take_start && !wr_period);

  // Writing the period restarts the count from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 16'h0;
      per_cnt <= 22'h0;
      start_req <= 1'b0;
    end else begin
      start_req <= next_start_req;
      if (wr_period) begin
        ms_cnt <= 16'h0;
        per_cnt <= 22'h0;
      end else begin
        ms_cnt <= ms_tick ? 16'h0 : ms_cnt + 16'h1;
        if (ms_tick) per_cnt <= period_hit ? 22'h0 : per_cnt + 22'h1;
      end
    end
  end

  // ****************************************
  // Channel search within the current group
  // ****************************************
  wire [23:0] cand;
  genvar gi;
  generate
    for (gi = 0; gi < CHAN_COUNT; gi++) begin : g_cand
      // Cells form group 0, aux channels group 1
      wire in_grp = (gi < CELL_COUNT) ? !grp : grp;
      assign cand[gi] = run_sel[gi] && in_grp && (5'(gi) >= from);
    end
  endgenerate
  wire found = (cand != 24'h0);
  wire grp_any = grp ? (run_sel[23:16] != 8'h0) : (run_sel[15:0] != 16'h0);
  logic [4:0] found_idx;

  // Lowest selected channel at or above the search start
  always_comb begin
    found_idx = 5'h0;
    for (int i = CHAN_COUNT - 1; i >= 0; i--) begin
      if (cand[i]) found_idx = 5'(i);
    end
  end

  // ****************************************
  // Settling and averaging period selection
  // ****************************************
  function automatic logic [15:0] code_cycles(input logic [3:0] code);
    logic [15:0] c;
    c = 16'(ns_to_cycles(INTERVAL_NS[code]));
    if (code == IVL_200US) c = 16'(IVL_200US_CYCLES);
    if (code == IVL_500US) c = 16'(IVL_500US_CYCLES);
    if (code == IVL_1000US) c = 16'(IVL_1000US_CYCLES);
    return c;
  endfunction

  wire [4:0] wch = (state == ST_SEEK) ? found_idx : ch;
  wire wch_cell = (wch < 5'(CELL_COUNT));
  wire [3:0] aux_code = aux_interval[{wch[2:0], 2'b00} +: 4];
  wire [3:0] first_code = wch_cell ? cell_interval[CELL_IVL_LSB +: 4] : aux_code;
  // Only code 3 is legal for the analog period, so all codes run at 12.6 us
  wire [3:0] analog_code = ANALOG_PERIOD_IVL;
  wire [3:0] digital_code = DIGITAL_PERIOD_IVL[avg_ctrl[DIGITAL_LSB +: 2]];
  wire [3:0] period_code = wch_cell ? analog_code : digital_code;
  // The order bit only changes how cell and aux samples are spaced and ordered
  wire use_first = run_order || (state == ST_SEEK);
  wire [15:0] first_load = code_cycles(first_code);
  wire [15:0] per_load = code_cycles(period_code);
  wire [15:0] wait_load = use_first ? first_load : per_load;
  wire conv_end = (state == ST_CONV) && adc_done;
  wire samp_more = (samp != run_last);
  // Count code 0..5 selects 1..32 samples
  wire [4:0] last_code = 5'((6'h1 << avg_ctrl[COUNT_LSB +: 3]) - 6'h1);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      ch <= 5'h0;
      from <= 5'h0;
      grp <= 1'b0;
      samp <= 5'h0;
      wait_cnt <= 16'h0;
      run_order <= 1'b0;
      run_count <= 3'h0;
      run_last <= 5'h0;
      run_sel <= 24'h0;
      adc_start <= 1'b0;
      adc_channel <= 5'h0;
      scan_busy <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          // Order, count and mask are frozen per scan; the intervals and the digital period are read live
          if (take_start) begin
            run_order <= avg_ctrl[ORDER_BIT];
            run_count <= avg_ctrl[COUNT_LSB +: 3];
            run_last <= last_code;
            run_sel <= {scan_mask[15:8], scan_mask[31:16]};
            grp <= 1'b0;
            from <= 5'h0;
            samp <= 5'h0;
            scan_busy <= 1'b1;
            state <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          if (found) begin
            ch <= found_idx;
            wait_cnt <= wait_load;
            state <= ST_SETTLE;
          end else if (run_order && grp_any && samp_more) begin
            samp <= samp + 5'h1;
            from <= grp ? 5'(CELL_COUNT) : 5'h0;
          end else if (!grp) begin
            grp <= 1'b1;
            from <= 5'(CELL_COUNT);
            samp <= 5'h0;
          end else begin
            scan_busy <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_SETTLE: begin
          if (wait_cnt == 16'h1) begin
            adc_start <= 1'b1;
            adc_channel <= ch;
            state <= ST_CONV;
          end else begin
            wait_cnt <= wait_cnt - 16'h1;
          end
        end
        ST_CONV: begin
          if (adc_done) begin
            if (!run_order && samp_more) begin
              samp <= samp + 5'h1;
              wait_cnt <= wait_load;
              state <= ST_SETTLE;
            end else begin
              if (!run_order) samp <= 5'h0;
              from <= ch + 5'h1;
              state <= ST_SEEK;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Accumulation and result store
  // ****************************************
  wire [20:0] new_sum = ((samp == 5'h0) ? 21'h0 : acc[ch]) + {5'h0, adc_result};
  wire store_now = conv_end && !samp_more;
  logic [15:0] avg_value;

  amo_round u_round (
    .sum(new_sum),
    .shift(run_count),
    .avg(avg_value)
  );

  // Running sums need no reset: the first sample always loads
  always_ff @(posedge pclk) begin
    if (conv_end) acc[ch] <= new_sum;
  end

  // Stored averages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CHAN_COUNT; i++) results[i] <= 16'h0;
    end else if (store_now) begin
      results[ch] <= avg_value;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire [21:0] scaled = 22'({avg_value, 5'h0} >> (3'h5 - run_count));
  wire [21:0] half_lsb = 22'((22'h1 << run_count) >> 1);

  mask_hit_a: assert property (adc_start |-> run_sel[adc_channel])
    else $error("conversion on an unselected channel");
  group_order_a: assert property ((grp && state != ST_IDLE) |=> (grp || state == ST_IDLE))
    else $error("cell sampling resumed after aux group began");
  same_chan_a: assert property ((conv_end && !run_order && samp_more) |=>
    (state == ST_SETTLE && $stable(ch) && wait_cnt == $past(per_load)))
    else $error("same-channel order left channel or used wrong period");
  cycle_move_a: assert property ((conv_end && run_order) |=>
    (state == ST_SEEK && from == $past(ch) + 5'h1))
    else $error("cycling order did not move to next channel");
  settle_len_a: assert property ((state == ST_SEEK && found && run_order) |=>
    (state == ST_SETTLE && wait_cnt == $past(first_load)))
    else $error("cycling settle time not from channel interval");
  timer_restart_a: assert property (wr_period |=> (ms_cnt == 16'h0 && per_cnt == 22'h0))
    else $error("period write did not restart timer");
  monitor_off_a: assert property ((state == ST_IDLE && scan_period == 4'h0 && !start_req)
    |=> state == ST_IDLE)
    else $error("scan started with monitoring off");
  count_legal_a: assert property (avg_ctrl[COUNT_LSB +: 3] <= MAX_COUNT_CODE)
    else $error("reserved sample count code held");
  round_err_a: assert property (store_now |-> ((avg_value == 16'hffff) ||
    ((scaled + half_lsb >= {1'b0, new_sum}) && (scaled <= {1'b0, new_sum} + half_lsb))))
    else $error("stored average not within half an LSB");

endmodule

`default_nettype wire

// ==== verif/test_auto_monitor_oversampling.sv ====
// Self-checking bench for the auto-monitor oversampling sequencer
`default_nettype none

module test_auto_monitor_oversampling
  import amo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals, clock and ADC stand-in
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic pready, pslverr, adc_start, scan_busy, last_err, fire;
  logic [31:0] prdata, d;
  logic [4:0] adc_channel;
  logic adc_done = 1'b0;
  logic [15:0] adc_result = '0;
  logic [15:0] v;
  logic [20:0] sum [24];
  logic [4:0] ch_log [$];
  int gap_log [$];
  int cnt [24];
  int cyc = 0;
  int last_done = 0;
  int wait_n = 0;
  int n_errors = 0;
  int n_checks = 0;
  int n_seen = 0;
  // Digital group period codes in ns, cell averaging period fixed at 12.6 us
  int dig_ns [4] = '{4130, 5960, 8020, 12600};
  localparam logic [7:0] CELL_IV = 8'h30;
  localparam logic [31:0] AUX_IV = 32'h0000_0053;

  always #20 pclk = ~pclk;

  amo_sequencer #(.MS_CYCLES(20), .IVL_200US_CYCLES(8), .IVL_500US_CYCLES(8),
    .IVL_1000US_CYCLES(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_done(adc_done), .adc_result(adc_result), .scan_busy(scan_busy));

  // Converter answers three cycles after each start; values climb per sample
  // so that half-way sums show up in the rounding
  always @(posedge pclk) begin
    cyc++;
    fire = (adc_start !== 1'b1) && (wait_n == 1);
    if (adc_start === 1'b1) begin
      ch_log.push_back(adc_channel);
      gap_log.push_back(cyc - last_done);
      wait_n = 3;
    end else if (wait_n != 0) begin
      wait_n--;
    end
    if (fire) begin
      v = 16'(256 + adc_channel * 64 + cnt[adc_channel]);
      adc_result <= v;
      sum[adc_channel] += 21'(v);
      cnt[adc_channel]++;
      last_done = cyc;
    end
    adc_done <= fire;
  end

  // ****************************************
  // Report and compare tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // APB master
  // ****************************************
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, idx, wd, x);
  endtask

  // Convergent rounding of a sum of 2^k samples
  function automatic logic [15:0] rnd(input logic [20:0] s, input int k);
    logic [20:0] q;
    logic [20:0] r;
    logic [20:0] h;
    if (k == 0) return s[15:0];
    q = s >> k;
    r = s & ((21'h1 << k) - 21'h1);
    h = 21'h1 << (k - 1);
    if (r > h || (r == h && q[0])) q = q + 21'h1;
    return (q > 21'h00ffff) ? 16'hffff : q[15:0];
  endfunction

  // ****************************************
  // One scan and its expected order, timing and results
  // ****************************************
  // Period written nonzero then zero, so exactly one scan runs
  task automatic do_scan(input logic [7:0] ctrl, input logic [31:0] msk);
    int n;
    int k;
    int ne;
    int ns;
    int base;
    logic [4:0] grp [$];
    logic [4:0] ec [$];
    logic ef [$];
    k = int'(ctrl[2:0]);
    wr(IDX_AVG_CTRL, {24'h0, ctrl});
    wr(IDX_SCAN_MASK, msk);
    for (int c = 0; c < 24; c++) begin
      sum[c] = '0;
      cnt[c] = 0;
    end
    ch_log.delete();
    gap_log.delete();
    wr(IDX_SCAN_PERIOD, 32'h1);
    wr(IDX_SCAN_PERIOD, 32'h0);
    chk1(scan_busy, 1'b1);
    n = 0;
    while (scan_busy !== 1'b0 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40000) begin
      n_errors++;
      end_of_test();
    end
    repeat (60) @(posedge pclk);
    for (int g = 0; g < 2; g++) begin
      grp.delete();
      for (int c = 0; c < 24; c++) begin
        if ((c < 16) == (g == 0) && (c < 16 ? msk[16 + c] : msk[c - 8])) grp.push_back(5'(c));
      end
      // Same-channel positions count from the start of this group
      base = ec.size();
      for (int p = 0; p < (1 << k); p++) begin
        foreach (grp[i]) begin
          ec.push_back(grp[ctrl[7] ? i : ((ec.size() - base) / (1 << k)) % grp.size()]);
          ef.push_back(ctrl[7] || (ec.size() - 1 - base) % (1 << k) == 0);
        end
      end
    end
    chk32(32'(ch_log.size()), 32'(ec.size()));
    for (int i = 0; i < ec.size() && i < ch_log.size(); i++) begin
      chk32({27'h0, ch_log[i]}, {27'h0, ec[i]});
      if (ec[i] < 16) ns = ef[i] ? INTERVAL_NS[CELL_IV[7:4]] : 12600;
      else ns = ef[i] ? INTERVAL_NS[4'(AUX_IV >> (4 * (ec[i] - 16)))] : dig_ns[ctrl[4:3]];
      ne = (ns + 39) / 40;
      if (i > 0) chk1(gap_log[i] >= ne && gap_log[i] <= ne + 5, 1'b1);
    end
    for (int c = 0; c < 24; c++) begin
      if (c < 16 ? msk[16 + c] : msk[c - 8]) begin
        apb(1'b0, IDX_RESULT_BASE + 8'(c), 32'h0, d);
        chk32(d, {16'h0, rnd(sum[c], k)});
      end
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_AVG_CTRL, 32'h0, d);
    chk32(d, {24'h0, AVG_CTRL_RESET});
    apb(1'b0, IDX_SCAN_PERIOD, 32'h0, d);
    chk32(d, {28'h0, SCAN_PERIOD_RESET});
    apb(1'b0, IDX_RESULT_BASE, 32'h0, d);
    chk32(d, 32'h0);
    apb(1'b0, IDX_STATUS, 32'h0, d);
    chk32(d & 32'h800, 32'h0);
    // Unmapped index answers with an error and no data
    apb(1'b0, 8'h01, 32'h0, d);
    chk1(last_err, 1'b1);
    chk32(d, 32'h0);
    // Reserved count codes fold down to the largest legal one
    wr(IDX_AVG_CTRL, 32'hff);
    apb(1'b0, IDX_AVG_CTRL, 32'h0, d);
    chk32(d, 32'hfd);
    // Unused mask bits read back as zero
    wr(IDX_SCAN_MASK, 32'hffff_ffff);
    apb(1'b0, IDX_SCAN_MASK, 32'h0, d);
    chk32(d, SCAN_MASK_WMASK);
    chk1(last_err, 1'b0);
    wr(IDX_CELL_INTERVAL, {24'h0, CELL_IV});
    wr(IDX_AUX_INTERVAL, AUX_IV);
    // Same-channel then cycling order over cells 0 and 2 and aux 1
    do_scan(8'h6a, 32'h0005_0200);
    // Result memory ignores writes
    wr(IDX_RESULT_BASE, 32'hffff);
    apb(1'b0, IDX_RESULT_BASE, 32'h0, d);
    chk32(d, {16'h0, rnd(sum[0], 2)});
    do_scan(8'hf9, 32'h0005_0200);
    // Every count code and every digital period code on aux 0
    for (int c = 0; c < 6; c++) begin
      do_scan({1'b0, 2'b11, 2'(c % 4), 3'(c)}, 32'h0000_0100);
    end
    // A period shorter than one scan keeps scans back to back until period 0
    wr(IDX_AVG_CTRL, 32'h78);
    wr(IDX_SCAN_MASK, 32'h100);
    ch_log.delete();
    wr(IDX_SCAN_PERIOD, 32'h3);
    repeat (900) @(posedge pclk);
    chk1(ch_log.size() >= 3, 1'b1);
    wr(IDX_SCAN_PERIOD, 32'h0);
    n_seen = 0;
    while (scan_busy !== 1'b0 && n_seen < 2000) begin
      @(posedge pclk);
      n_seen++;
    end
    if (n_seen >= 2000) begin
      n_errors++;
      end_of_test();
    end
    n_seen = ch_log.size();
    repeat (400) @(posedge pclk);
    chk32(32'(ch_log.size()), 32'(n_seen));
    end_of_test();
  end

endmodule

`default_nettype wire
